// ---- sdm_consts.vh ----
// constants for the serial debug memory port
`ifndef SDM_CONSTS_VH
`define SDM_CONSTS_VH

// command codes
`define SDM_CMD_WRITE 8'h02
`define SDM_CMD_READ 8'h03

// field widths
`define SDM_CMD_W 8
`define SDM_ADDR_W 16
`define SDM_DATA_W 16

// last bit index inside a command byte and inside a 16-bit field
`define SDM_CMD_LAST 4'h7
`define SDM_WORD_LAST 4'hf

// pin indices in the synchroniser vector
`define SDM_PIN_CS 0
`define SDM_PIN_SCK 1
`define SDM_PIN_DIN 2
`define SDM_PIN_N 3

// reset values
`define SDM_PINS_RST 3'h1
`define SDM_ADDR_RST 16'h0000
`define SDM_DATA_RST 16'h0000

// write buffer shape
`define SDM_FIFO_DEPTH 8
`define SDM_FIFO_AW 3

`endif

// ---- sdm_debug_port.v ----
// serial debug memory port: pin sampling, sequencer and write buffer
`timescale 1ns/1ns
`default_nettype none
`include "sdm_consts.vh"

// Function
// R1 - chip select rising ends the transaction and drops any partial word
// R2 - master keeps chip select low for the whole transaction
// R3 - data-in is sampled on each rising serial clock edge
// R4 - during reads data-out changes on each falling serial clock edge
// R5 - the master makes the serial clock; the device never drives it
// R6 - each further 16 clocks with select low moves one word, next address
// R7 - write opens with command 02, then 16-bit address, then data words
// R8 - writes store first word at address, later words at following addresses
// R9 - read opens with command 03, then the 16-bit start address
// R10 - reads return a check word, then the addressed contents
// R11 - check word is command byte above upper eight address bits
// R12 - reads continue with each next location every 16 clocks
// R13 - deselected data-out driven low when running, high when stopped
// R14 - data-out must not be wired in parallel with other slaves
// R15 - select held high resets the port to expect a command byte
// R16 - master lowers select then sends the command byte before the address
// R17 - 16-bit addresses and data, usable whether processor runs or stops
// R18 - fields go msb first; unknown commands touch no memory
// R19 - the address counter wraps from ffff to zero

// ----------------------------------------------------------------
// write buffer
// ----------------------------------------------------------------
module sdm_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = `SDM_FIFO_DEPTH,
  parameter AW = `SDM_FIFO_AW
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign in_ready_out = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_q[rd_ptr_q];

  always @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// port top
// ----------------------------------------------------------------
module sdm_debug_port (
  input wire mclk_in,
  input wire arst_n_in,
  input wire cs_n_in,
  input wire sck_in,
  input wire din_in,
  output wire dout_out,
  output wire dout_oe_n_out,
  input wire cpu_stopped_in,
  output wire mem_wr_valid_out,
  input wire mem_wr_ready_in,
  output wire [15:0] mem_wr_addr_out,
  output wire [15:0] mem_wr_data_out,
  output wire mem_rd_req_out,
  output wire [15:0] mem_rd_addr_out,
  input wire mem_rd_valid_in,
  input wire [15:0] mem_rd_data_in
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [`SDM_PIN_N-1:0] sync1_q;
  reg [`SDM_PIN_N-1:0] sync2_q;
  reg [`SDM_PIN_N-1:0] sync3_q;
  reg [`SDM_PIN_N-1:0] pin_q;
  reg [`SDM_PIN_N-1:0] pin_prev_q;
  wire [`SDM_PIN_N-1:0] pin_raw;
  wire [`SDM_PIN_N-1:0] pin_d;

  assign pin_raw = {din_in, sck_in, cs_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < `SDM_PIN_N; gi = gi + 1) begin : g_pin
      // a level counts only once the two later stages agree
      assign pin_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : pin_q[gi];
    end
  endgenerate

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_q <= `SDM_PINS_RST;
      sync2_q <= `SDM_PINS_RST;
      sync3_q <= `SDM_PINS_RST;
      pin_q <= `SDM_PINS_RST;
      pin_prev_q <= `SDM_PINS_RST;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= pin_d;
      pin_prev_q <= pin_q;
    end
  end

  wire cs_active;
  wire sck_rise;
  wire sck_fall;
  wire din_bit;

  // the serial clock is only ever an input here
  assign cs_active = ~pin_q[`SDM_PIN_CS]; // R5
  assign sck_rise = pin_q[`SDM_PIN_SCK] & ~pin_prev_q[`SDM_PIN_SCK];
  assign sck_fall = ~pin_q[`SDM_PIN_SCK] & pin_prev_q[`SDM_PIN_SCK];
  assign din_bit = pin_q[`SDM_PIN_DIN];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  reg [2:0] state_q;
  localparam [2:0] ST_CMD = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_IGNORE = 3'h4;
  reg [3:0] bit_cnt_q;
  reg [15:0] shift_q;
  reg [7:0] cmd_q;
  reg [15:0] addr_q;
  reg [15:0] tx_q;
  reg dout_q;
  reg rd_req_q;
  reg [15:0] rd_addr_q;
  reg [15:0] rd_buf_q;
  reg wr_pend_q;
  reg [15:0] wr_addr_q;
  reg [15:0] wr_data_q;
  wire fifo_in_ready;
  wire [15:0] rx_word;
  wire [7:0] rx_cmd;

  // msb first: new bit enters at the bottom
  assign rx_word = {shift_q[14:0], din_bit}; // R18
  assign rx_cmd = rx_word[7:0];

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_CMD;
      bit_cnt_q <= 4'h0;
      shift_q <= `SDM_DATA_RST;
      cmd_q <= 8'h00;
      addr_q <= `SDM_ADDR_RST;
      tx_q <= `SDM_DATA_RST;
      dout_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_addr_q <= `SDM_ADDR_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= `SDM_ADDR_RST;
      wr_data_q <= `SDM_DATA_RST;
    end else begin
      rd_req_q <= 1'b0;
      if (wr_pend_q && fifo_in_ready) begin
        wr_pend_q <= 1'b0;
      end
      if (!cs_active) begin
        // deselect drops partial words and rearms for a command byte
        state_q <= ST_CMD; // R1 R15
        bit_cnt_q <= 4'h0; // R1
        shift_q <= `SDM_DATA_RST;
        dout_q <= cpu_stopped_in; // R13
      end else if (sck_rise) begin
        shift_q <= rx_word; // R3
        bit_cnt_q <= bit_cnt_q + 4'h1;
        case (state_q)
          ST_CMD: begin
            if (bit_cnt_q == `SDM_CMD_LAST) begin
              cmd_q <= rx_cmd;
              bit_cnt_q <= 4'h0;
              if (rx_cmd == `SDM_CMD_WRITE || rx_cmd == `SDM_CMD_READ) begin
                state_q <= ST_ADDR; // R7 R9 R16
              end else begin
                state_q <= ST_IGNORE; // R18
              end
            end
          end
          ST_ADDR: begin
            if (bit_cnt_q == `SDM_WORD_LAST) begin
              addr_q <= rx_word; // R17
              if (cmd_q == `SDM_CMD_READ) begin
                state_q <= ST_RDATA;
                tx_q <= {cmd_q, rx_word[15:8]}; // R10 R11
                rd_req_q <= 1'b1;
                rd_addr_q <= rx_word; // R9
              end else begin
                state_q <= ST_WDATA; // R7
              end
            end
          end
          ST_WDATA: begin
            if (bit_cnt_q == `SDM_WORD_LAST) begin
              // one word in flight beyond the buffer; a full buffer for
              // a whole word time overwrites it
              wr_pend_q <= 1'b1; // R8
              wr_addr_q <= addr_q; // R8
              wr_data_q <= rx_word;
              addr_q <= addr_q + 16'h0001; // R6 R19
            end
          end
          ST_RDATA: begin
            if (bit_cnt_q == `SDM_WORD_LAST) begin
              // prefetch leaves a whole word time for the memory answer
              tx_q <= rd_buf_q; // R10 R12
              rd_req_q <= 1'b1;
              rd_addr_q <= addr_q + 16'h0001; // R12 R19
              addr_q <= addr_q + 16'h0001; // R6
            end
          end
          ST_IGNORE: begin
            bit_cnt_q <= 4'h0;
          end
          default: begin
            state_q <= ST_IGNORE;
          end
        endcase
      end else if (sck_fall) begin
        if (state_q == ST_RDATA) begin
          dout_q <= tx_q[15]; // R4
          tx_q <= {tx_q[14:0], 1'b0};
        end else begin
          dout_q <= 1'b0;
        end
      end
    end
  end

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_buf_q <= `SDM_DATA_RST;
    end else if (mem_rd_valid_in) begin
      rd_buf_q <= mem_rd_data_in;
    end
  end

  // ----------------------------------------------------------------
  // outputs and write buffer
  // ----------------------------------------------------------------
  // never released, so the line cannot be shared with other slaves
  assign dout_out = dout_q; // R13 R14
  assign dout_oe_n_out = 1'b0; // R13
  assign mem_rd_req_out = rd_req_q;
  assign mem_rd_addr_out = rd_addr_q;

  wire [31:0] fifo_out_data;

  sdm_fifo #(
    .WIDTH(32),
    .DEPTH(`SDM_FIFO_DEPTH),
    .AW(`SDM_FIFO_AW)
  ) u_wr_fifo (
    .clk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(wr_pend_q),
    .in_ready_out(fifo_in_ready),
    .in_data_in({wr_addr_q, wr_data_q}),
    .out_valid_out(mem_wr_valid_out),
    .out_ready_in(mem_wr_ready_in),
    .out_data_out(fifo_out_data)
  );

  assign mem_wr_addr_out = fifo_out_data[31:16];
  assign mem_wr_data_out = fifo_out_data[15:0];

endmodule

`default_nettype wire

// ---- sdm_debug_port_props.sv ----
// concurrent checks on the serial debug memory port pins
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module sdm_debug_port_props (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic din_in,
  input wire logic dout_out,
  input wire logic dout_oe_n_out,
  input wire logic cpu_stopped_in,
  input wire logic mem_wr_valid_out,
  input wire logic mem_wr_ready_in,
  input wire logic [15:0] mem_wr_addr_out,
  input wire logic [15:0] mem_wr_data_out,
  input wire logic mem_rd_req_out,
  input wire logic [15:0] mem_rd_addr_out,
  input wire logic mem_rd_valid_in,
  input wire logic [15:0] mem_rd_data_in
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  a_oe_drive: assert property (dout_oe_n_out == 1'h0)
    else $error("data out not driven");
  a_idle_level: assert property (cs_n_in [*8] |-> dout_out == $past(cpu_stopped_in))
    else $error("idle data out level wrong");
  a_dout_on_fall: assert property (!cs_n_in && $changed(dout_out) |-> !sck_in && !$past(sck_in, 4))
    else $error("data out moved outside low clock phase");
  a_rdreq_pulse: assert property (mem_rd_req_out |=> !mem_rd_req_out)
    else $error("read request longer than one cycle");
  a_rdreq_on_rise: assert property (mem_rd_req_out |-> sck_in && $past(sck_in, 3))
    else $error("read request not after a clock rise");
  a_rdaddr_hold: assert property ($changed(mem_rd_addr_out) |-> mem_rd_req_out)
    else $error("read address moved without request");
  a_wr_hold: assert property (mem_wr_valid_out && !mem_wr_ready_in |=>
    mem_wr_valid_out && $stable(mem_wr_addr_out) && $stable(mem_wr_data_out))
    else $error("stalled write changed");
  a_wr_on_rise: assert property ($rose(mem_wr_valid_out) |-> sck_in && !cs_n_in)
    else $error("write appeared outside a word end");
  c_read: cover property (mem_rd_req_out);
  c_stall: cover property (mem_wr_valid_out && !mem_wr_ready_in);
  c_write: cover property (mem_wr_valid_out && mem_wr_ready_in);
endmodule
bind sdm_debug_port sdm_debug_port_props chk_u (.*);
`default_nettype wire

// ---- sdm_debug_port_tb.sv ----
// self-checking bench for the serial debug memory port
`timescale 1ns/1ns
`default_nettype none
`include "sdm_consts.vh"
module sdm_debug_port_tb;
  logic mclk_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic cpu_stopped_in = 1'h0;
  logic mem_wr_ready_in = 1'h1;
  logic mem_rd_valid_in = 1'h0;
  logic [15:0] mem_rd_data_in = 16'h0000;
  wire cs_n, sck, din, dout_out, dout_oe_n_out, mem_wr_valid_out, mem_rd_req_out;
  wire [15:0] mem_wr_addr_out, mem_wr_data_out, mem_rd_addr_out;
  logic [15:0] mem [0:65535];
  logic [15:0] rd_a = 16'h0000;
  logic [31:0] wr_q[$];
  bit tx[$];
  bit stall = 1'b0;
  int num_errors = 0, cmp_count = 0, seed = 99, rd_cnt = 0, rq = 0, n;
  always #2 mclk_in = ~mclk_in;
  sdm_master mst_u (.mclk_in(mclk_in), .cs_n_out(cs_n), .sck_out(sck), .din_out(din),
    .dout_in(dout_out));
  sdm_debug_port dut_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .cs_n_in(cs_n),
    .sck_in(sck), .din_in(din), .dout_out(dout_out), .dout_oe_n_out(dout_oe_n_out),
    .cpu_stopped_in(cpu_stopped_in), .mem_wr_valid_out(mem_wr_valid_out),
    .mem_wr_ready_in(mem_wr_ready_in), .mem_wr_addr_out(mem_wr_addr_out),
    .mem_wr_data_out(mem_wr_data_out), .mem_rd_req_out(mem_rd_req_out),
    .mem_rd_addr_out(mem_rd_addr_out), .mem_rd_valid_in(mem_rd_valid_in),
    .mem_rd_data_in(mem_rd_data_in));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // memory side: random stalls, late read answers
  // ----------------------------------------------------------------
  always @(posedge mclk_in) begin
    mem_wr_ready_in <= !stall && ($random(seed) % 4 != 0);
    mem_rd_valid_in <= (rd_cnt == 1);
    mem_rd_data_in <= (rd_cnt == 1) ? mem[rd_a] : 16'($random(seed));
    if (rd_cnt != 0) rd_cnt <= rd_cnt - 1;
    if (mem_rd_req_out) begin
      rd_a <= mem_rd_addr_out;
      rd_cnt <= 1 + ($random(seed) & 3);
      rq++;
    end
    if (mem_wr_valid_out && mem_wr_ready_in) begin
      check("write expected", 16'(wr_q.size() != 0), 16'h0001);
      if (wr_q.size() != 0) begin
        check("write addr", mem_wr_addr_out, wr_q[0][31:16]);
        check("write data", mem_wr_data_out, wr_q[0][15:0]);
        mem[wr_q[0][31:16]] <= wr_q[0][15:0];
        void'(wr_q.pop_front());
      end
    end
  end
  task automatic put(input logic [15:0] v);
    for (int b = 15; b >= 0; b--) tx.push_back(v[b]);
  endtask
  task automatic hdr(input logic [23:0] v);
    for (int b = 23; b >= 0; b--) tx.push_back(v[b]);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] a, input int k_n);
    logic [15:0] d;
    tx = {};
    hdr({c, a});
    for (int k = 0; k < k_n; k++) begin
      d = 16'($random(seed));
      put(d);
      if (c == `SDM_CMD_WRITE) wr_q.push_back({16'(a + k), d});
    end
    repeat (8) tx.push_back(1'b1);
    mst_u.frame(tx);
  endtask
  task automatic drain();
    for (int t = 0; t < 400 && wr_q.size() != 0; t++) @(posedge mclk_in);
    check("writes left", 16'(wr_q.size()), 16'h0000);
    if (wr_q.size() != 0) end_of_test();
  endtask
  task automatic rd(input logic [15:0] a, input int k_n);
    logic [15:0] v;
    tx = {};
    hdr({`SDM_CMD_READ, a});
    repeat (16 * (k_n + 1)) tx.push_back(1'($random(seed)));
    mst_u.frame(tx);
    for (int k = 0; k <= k_n; k++) begin
      for (int b = 0; b < 16; b++) v[15 - b] = mst_u.rx_q[24 + 16 * k + b];
      check("read word", v, k ? mem[16'(a + k - 1)] : {`SDM_CMD_READ, a[15:8]});
    end
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 16'(i) ^ 16'ha5a5;
    repeat (8) @(posedge mclk_in);
    arst_n_in <= 1'h1;
    repeat (8) @(posedge mclk_in);
    for (int s = 0; s < 2; s++) begin
      cpu_stopped_in <= s[0];
      repeat (3) @(posedge mclk_in);
      check("idle dout", 16'(dout_out), 16'(s));
      check("dout enable", 16'(dout_oe_n_out), 16'h0000);
    end
    $display("idle level test done");
    stall <= 1'b1;
    wr(`SDM_CMD_WRITE, 16'hfffa, 9);
    check("stalled valid", 16'(mem_wr_valid_out), 16'h0001);
    stall <= 1'b0;
    drain();
    rd(16'hfffa, 9);
    $display("full buffer and wrap test done");
    n = rq;
    wr(8'h55, 16'h1234, 2);
    drain();
    check("bad command reads", 16'(rq - n), 16'h0000);
    $display("unknown command test done");
    repeat (4) begin
      n = $random(seed);
      cpu_stopped_in <= n[16];
      wr(`SDM_CMD_WRITE, 16'(n), 2);
      drain();
      rd(16'(n), 2);
      check("idle dout", 16'(dout_out), 16'(n[16]));
    end
    $display("random access test done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- sdm_master.sv ----
// serial master model for the debug link
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// master
// ----------------------------------------------------------------
module sdm_master (
  input wire logic mclk_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic din_out,
  input wire logic dout_in
);
  bit rx_q[$];
  initial begin
    cs_n_out = 1'h1;
    sck_out = 1'h0;
    din_out = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // 160 ns clock, still between frames; reply read at each rise
  task automatic frame(input bit tx[$]);
    rx_q = {};
    cs_n_out <= 1'h0;
    tick(20);
    foreach (tx[i]) begin
      din_out <= tx[i];
      tick(20);
      sck_out <= 1'h1;
      rx_q.push_back(dout_in);
      tick(20);
      sck_out <= 1'h0;
    end
    tick(20);
    cs_n_out <= 1'h1;
    din_out <= ~din_out;
    tick(80);
  endtask
endmodule
`default_nettype wire
